// [inc/sac_consts.svh]
// Constants for the SAR converter control block
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// ----------------------------------------------------------------
// Conversion geometry and timing
// ----------------------------------------------------------------
`define SAC_DATA_BITS      13
`define SAC_TRACK_EDGE     14
`define SAC_FRAME_BITS     16
`define SAC_CNT_W          5

// ----------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------
`define SAC_RANGE_PM10     2'h0
`define SAC_RANGE_PM5      2'h1
`define SAC_RANGE_PM2P5    2'h2
`define SAC_RANGE_UNI10    2'h3
`define SAC_MODE_SE        2'h0
`define SAC_MODE_DIFF      2'h1
`define SAC_MODE_PSEUDO    2'h2
`define SAC_PM_NORMAL      2'h0

// ----------------------------------------------------------------
// Reset values of the control fields
// ----------------------------------------------------------------
`define SAC_RST_RANGE      2'h0
`define SAC_RST_MODE       2'h0
`define SAC_RST_PM         2'h0
`define SAC_RST_REF_INT    1'h0
`define SAC_RST_STRAIGHT   1'h0

// ----------------------------------------------------------------
// Write mask bit positions
// ----------------------------------------------------------------
`define SAC_WM_STRAIGHT    0
`define SAC_WM_REF         1
`define SAC_WM_PM          2
`define SAC_WM_MODE        3
`define SAC_WM_RANGE0      4
`define SAC_WM_RANGE1      5
`define SAC_WM_W           6

// ----------------------------------------------------------------
// Step size per range, in nanovolts
// ----------------------------------------------------------------
`define SAC_LSB_W          22
`define SAC_LSB_NV_PM10    22'h2540be
`define SAC_LSB_NV_PM5     22'h12a05f
`define SAC_LSB_NV_PM2P5   22'h09502f

`endif

// [inc/sac_pkg.sv]
// Types for the SAR converter control block
`include "sac_consts.svh"
`default_nettype none

package sac_pkg;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAC_PM10   = `SAC_RANGE_PM10,
    SAC_PM5    = `SAC_RANGE_PM5,
    SAC_PM2P5  = `SAC_RANGE_PM2P5,
    SAC_UNI10  = `SAC_RANGE_UNI10
  } sac_range_t;

  typedef enum logic [1:0] {
    SAC_SE     = `SAC_MODE_SE,
    SAC_DIFF   = `SAC_MODE_DIFF,
    SAC_PSEUDO = `SAC_MODE_PSEUDO,
    SAC_RSVD   = 2'h3
  } sac_mode_t;

  typedef struct packed {
    sac_range_t range1;
    sac_range_t range0;
    sac_mode_t  mode;
    logic [1:0] pm;
    logic       ref_int;
    logic       straight;
  } sac_ctrl_t;

  // ----------------------------------------------------------------
  // Conversion sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAC_ST_IDLE  = 2'b00,
    SAC_ST_CONV  = 2'b01,
    SAC_ST_TRACK = 2'b10
  } sac_state_t;
endpackage : sac_pkg

`default_nettype wire

// [rtl/sac_adc_ctrl.sv]
// Control register, SAR sequencer and serial output of the converter
// Operation
// - In single-ended mode each channel keeps its own range (differential modes use range0): three bipolar, one unipolar 0 to 10 V.
// - Two mode bits pick single-ended, true differential or pseudo differential.
// - Power-up gives single-ended inputs; host writes to pick differential modes.
// - Power-up selects the external reference.
// - Writing the reference bit switches to the internal 2.5 V reference.
// - Serial clock shifts data out and steps the approximation.
// - Power-down between conversions is picked by the control register.
// - Results are twos complement until the host changes coding.
// - With the coding bit set, results come out straight binary.
// - In sequences every channel uses coding of the latest control write.
// - Input resolves to one of 8192 codes at whole LSB steps.
// - LSB weight follows the range: 2.441, 1.22 or 0.61 mV.
// - Approximate one bit on each of 13 serial clock rises, then declare completion and form 13-bit code.
// - Back-to-back conversions supported up to 1 MSPS; host stays within that.
// - Track resumes after the fourteenth serial clock rise from select falling.
// - Select falling switches track to hold, sampling the input.
// - Twos complement: most negative input -4096, most positive +4095.
`include "sac_consts.svh"
`default_nettype none

module sac_adc_ctrl #(
  parameter int DATA_BITS  = `SAC_DATA_BITS,
  parameter int TRACK_EDGE = `SAC_TRACK_EDGE
) (
  // Clock and reset
  input  wire logic                     CLK_IN,
  input  wire logic                     RESET_IN,
  // Serial link from the host
  input  wire logic                     SCLK_IN,
  input  wire logic                     CS_N_IN,
  output var  logic                     DOUT_OUT,
  // Analog front end
  input  wire logic                     COMP_IN,
  output var  logic [DATA_BITS-1:0]     DAC_CODE_OUT,
  output var  logic                     TRACK_OUT,
  output var  logic                     PDOWN_OUT,
  // Control port
  input  wire logic                     CHAN_IN,
  input  wire logic                     CTRL_WR_IN,
  input  wire logic [`SAC_WM_W-1:0]     CTRL_WMASK_IN,
  input  wire sac_pkg::sac_ctrl_t       CTRL_DATA_IN,
  output var  sac_pkg::sac_ctrl_t       CTRL_OUT,
  // Result
  output var  logic [DATA_BITS-1:0]     RESULT_OUT,
  output var  logic                     RESULT_VALID_OUT,
  output var  logic [`SAC_LSB_W-1:0]    LSB_NV_OUT
);
  import sac_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DATA_BITS < 2 || DATA_BITS > `SAC_FRAME_BITS || TRACK_EDGE <= DATA_BITS || TRACK_EDGE > 30) begin : g_bad
    $error("sac_adc_ctrl: unsupported DATA_BITS or TRACK_EDGE");
  end

  localparam logic [`SAC_CNT_W-1:0] TRACK_CNT = `SAC_CNT_W'(TRACK_EDGE);
  localparam logic [`SAC_CNT_W-1:0] LAST_BIT  = `SAC_CNT_W'(DATA_BITS);

  // Step size of a range
  function automatic logic [`SAC_LSB_W-1:0] range_lsb(input sac_range_t r);
    case (r)
      SAC_PM10:  range_lsb = `SAC_LSB_NV_PM10;
      SAC_PM2P5: range_lsb = `SAC_LSB_NV_PM2P5;
      default:   range_lsb = `SAC_LSB_NV_PM5; // 10 V span ranges
    endcase
  endfunction : range_lsb

  // ----------------------------------------------------------------
  // Synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] sclk_q;
  logic [2:0] csn_q;
  logic [1:0] comp_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;

  // Two stages before use, third stage only for edges
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      sclk_q <= 3'h0;
      csn_q  <= 3'h7;
      comp_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], SCLK_IN};
      csn_q  <= {csn_q[1:0], CS_N_IN};
      comp_q <= {comp_q[0], COMP_IN};
    end
  end

  // Edges seen on the clock of the block
  // Reset clears the clock history, so an idle-high clock shows one rise after reset;
  // harmless, since only the converting state counts rises
  always_comb begin
    sclk_rise = sclk_q[1] & ~sclk_q[2];
    sclk_fall = ~sclk_q[1] & sclk_q[2];
    cs_fall   = ~csn_q[1] & csn_q[2];
    cs_rise   = csn_q[1] & ~csn_q[2];
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  sac_ctrl_t ctrl_q;
  sac_ctrl_t ctrl_d;

  // Masked field update
  always_comb begin
    ctrl_d = ctrl_q;
    if (CTRL_WR_IN) begin
      if (CTRL_WMASK_IN[`SAC_WM_STRAIGHT]) ctrl_d.straight = CTRL_DATA_IN.straight;
      if (CTRL_WMASK_IN[`SAC_WM_REF])      ctrl_d.ref_int  = CTRL_DATA_IN.ref_int;
      if (CTRL_WMASK_IN[`SAC_WM_PM])       ctrl_d.pm       = CTRL_DATA_IN.pm;
      if (CTRL_WMASK_IN[`SAC_WM_MODE])     ctrl_d.mode     = CTRL_DATA_IN.mode;
      if (CTRL_WMASK_IN[`SAC_WM_RANGE0])   ctrl_d.range0   = CTRL_DATA_IN.range0;
      if (CTRL_WMASK_IN[`SAC_WM_RANGE1])   ctrl_d.range1   = CTRL_DATA_IN.range1;
    end
  end

  // Power-up defaults
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ctrl_q.range1   <= sac_range_t'(`SAC_RST_RANGE);
      ctrl_q.range0   <= sac_range_t'(`SAC_RST_RANGE);
      ctrl_q.mode     <= sac_mode_t'(`SAC_RST_MODE);
      ctrl_q.pm       <= `SAC_RST_PM;
      ctrl_q.ref_int  <= `SAC_RST_REF_INT;
      ctrl_q.straight <= `SAC_RST_STRAIGHT;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  sac_state_t                  st_q,    st_d;
  logic [`SAC_CNT_W-1:0]       cnt_q,   cnt_d;
  logic [DATA_BITS-1:0]        sar_q,   sar_d;
  logic [DATA_BITS-1:0]        res_q,   res_d;
  logic [`SAC_FRAME_BITS-1:0]  sh_q,    sh_d;
  logic [`SAC_LSB_W-1:0]       lsb_q,   lsb_d;
  logic                        track_q, track_d;
  logic                        valid_q, valid_d;
  logic                        pdown_q, pdown_d;
  logic [`SAC_CNT_W-1:0]       bit_idx;

  // Next state of the sequencer, SAR and output shifter
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sar_d   = sar_q;
    res_d   = res_q;
    sh_d    = sh_q;
    lsb_d   = lsb_q;
    track_d = track_q;
    valid_d = 1'b0;
    bit_idx = LAST_BIT - cnt_q - `SAC_CNT_W'(1);
    if (cs_fall) begin
      // Hold the sample, start a fresh approximation from midscale
      st_d    = SAC_ST_CONV;
      cnt_d   = '0;
      track_d = 1'b0;
      sar_d   = '0;
      sar_d[DATA_BITS-1] = 1'b1;
      sh_d    = '0;
      sh_d[DATA_BITS-1:0] = res_q;
      lsb_d   = range_lsb((ctrl_q.mode == SAC_SE && CHAN_IN) ? ctrl_q.range1 : ctrl_q.range0);
    end else if (cs_rise) begin
      st_d    = SAC_ST_IDLE;
      track_d = 1'b1;
    end else begin
      if (sclk_fall) begin
        sh_d = {sh_q[`SAC_FRAME_BITS-2:0], 1'b0};
      end
      if (sclk_rise && st_q == SAC_ST_CONV) begin
        cnt_d = cnt_q + `SAC_CNT_W'(1);
        if (cnt_q < LAST_BIT) begin
          // Keep the trial bit when input stands above the DAC, try the next
          for (int i = 0; i < DATA_BITS; i++) begin
            if (`SAC_CNT_W'(i) == bit_idx) sar_d[i] = comp_q[1];
            if (`SAC_CNT_W'(i + 1) == bit_idx) sar_d[i] = 1'b1;
          end
        end
        if (cnt_d == TRACK_CNT) begin
          // Complete: offset code is straight binary, flip sign for twos
          st_d    = SAC_ST_TRACK;
          track_d = 1'b1;
          valid_d = 1'b1;
          res_d   = sar_q;
          res_d[DATA_BITS-1] = sar_q[DATA_BITS-1] ^ ~ctrl_q.straight;
        end
      end
    end
    // Power-down follows the control value that stands after this edge
    pdown_d = (st_d == SAC_ST_IDLE) && (ctrl_d.pm != `SAC_PM_NORMAL);
  end

  // Sequencer registers
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_q    <= SAC_ST_IDLE;
      cnt_q   <= '0;
      sar_q   <= '0;
      res_q   <= '0;
      sh_q    <= '0;
      lsb_q   <= `SAC_LSB_NV_PM10;
      track_q <= 1'b1;
      valid_q <= 1'b0;
      pdown_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sar_q   <= sar_d;
      res_q   <= res_d;
      sh_q    <= sh_d;
      lsb_q   <= lsb_d;
      track_q <= track_d;
      valid_q <= valid_d;
      pdown_q <= pdown_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from flops
  // ----------------------------------------------------------------
  always_comb begin
    DOUT_OUT         = sh_q[`SAC_FRAME_BITS-1];
    DAC_CODE_OUT     = sar_q;
    TRACK_OUT        = track_q;
    PDOWN_OUT        = pdown_q;
    CTRL_OUT         = ctrl_q;
    RESULT_OUT       = res_q;
    RESULT_VALID_OUT = valid_q;
    LSB_NV_OUT       = lsb_q;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  hold_on_select_a: assert property (cs_fall |=> !track_q && st_q == SAC_ST_CONV)
    else $error("select falling did not enter hold");
  track_after_edge_a: assert property (
    (st_q == SAC_ST_CONV && sclk_rise && !cs_rise && !cs_fall && cnt_q == TRACK_CNT - `SAC_CNT_W'(1))
    |=> track_q && valid_q && st_q == SAC_ST_TRACK)
    else $error("track not resumed at the final edge");
  midscale_start_a: assert property (cs_fall |=> sar_q == {1'b1, {(DATA_BITS-1){1'b0}}})
    else $error("approximation did not start at midscale");
  coding_sign_a: assert property (
    valid_q |-> res_q[DATA_BITS-1] == ($past(sar_q[DATA_BITS-1]) ^ ~$past(ctrl_q.straight)))
    else $error("sign bit does not follow coding");
  ref_switch_a: assert property (CTRL_WR_IN && CTRL_WMASK_IN[`SAC_WM_REF]
    |=> ctrl_q.ref_int == $past(CTRL_DATA_IN.ref_int))
    else $error("reference bit not taken");
  field_keep_a: assert property (CTRL_WR_IN && !CTRL_WMASK_IN[`SAC_WM_MODE] |=> $stable(ctrl_q.mode))
    else $error("unwritten mode field changed");
  ctrl_idle_a: assert property (!CTRL_WR_IN |=> $stable(ctrl_q))
    else $error("control changed without a write");
  pdown_idle_a: assert property (pdown_q |-> st_q == SAC_ST_IDLE && ctrl_q.pm != `SAC_PM_NORMAL)
    else $error("power-down outside idle");
  shift_step_a: assert property (sclk_fall && !cs_fall && !cs_rise |=> DOUT_OUT == $past(sh_q[`SAC_FRAME_BITS-2]))
    else $error("output did not shift on serial clock fall");

  // Sequencer timing and result handling
  valid_single_a: assert property (
    valid_q |=> !valid_q)
    else $error("result valid longer than one cycle");
  result_keep_a: assert property (
    $changed(res_q) |-> valid_q)
    else $error("result changed without completion");
  sar_frozen_a: assert property (
    st_q != SAC_ST_CONV && !cs_fall |=> $stable(sar_q))
    else $error("trial code moved outside conversion");
  conv_count_a: assert property (
    st_q == SAC_ST_CONV |-> cnt_q < TRACK_CNT)
    else $error("edge count ran past the final edge");
  abort_track_a: assert property (
    cs_rise |=> track_q && !valid_q && st_q == SAC_ST_IDLE)
    else $error("select rising did not return to track");
  hold_in_conv_a: assert property (
    st_q == SAC_ST_CONV |-> !track_q)
    else $error("tracking during conversion");

  // Output framing, step size and control fields
  lead_zero_a: assert property (
    cs_fall |=> !DOUT_OUT)
    else $error("frame does not start with a zero bit");
  lsb_legal_a: assert property (
    lsb_q == `SAC_LSB_NV_PM10 || lsb_q == `SAC_LSB_NV_PM5 || lsb_q == `SAC_LSB_NV_PM2P5)
    else $error("step size is not one of the range values");
  coding_take_a: assert property (
    CTRL_WR_IN && CTRL_WMASK_IN[`SAC_WM_STRAIGHT] |=> ctrl_q.straight == $past(CTRL_DATA_IN.straight))
    else $error("coding bit not taken");
  range_keep_a: assert property (
    CTRL_WR_IN && !CTRL_WMASK_IN[`SAC_WM_RANGE0] |=> $stable(ctrl_q.range0))
    else $error("unwritten range field changed");
endmodule : sac_adc_ctrl

`default_nettype wire

// [sim/sac_host_model.sv]
// Host serial port and comparator model facing the converter
`default_nettype none

module sac_host_model (
  // Clock
  input  wire logic        clk_in,
  // Device side
  input  wire logic        dout_in,
  input  wire logic        track_in,
  input  wire logic [12:0] dac_in,
  input  wire logic [12:0] ain_in,
  output var  logic        sclk_out,
  output var  logic        cs_n_out,
  output var  logic        comp_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] word;
  logic        trk_hold;
  logic        trk13;
  logic        trk14;

  // Idle levels, serial clock stands high outside frames
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    comp_out = 1'b0;
  end

  // Comparator: high while the input is at or above the trial code
  always @(posedge clk_in) begin
    comp_out <= #1 (ain_in >= dac_in);
  end

  // One frame, bits read before each falling edge, 160 ns period
  task automatic frame(input int rises);
    cs_n_out = 1'b0;
    #160;
    trk_hold = track_in;
    for (int i = 0; i < rises; i++) begin
      word[15-i] = dout_in;
      sclk_out = 1'b0;
      #80;
      sclk_out = 1'b1;
      #80;
      if (i == 12) trk13 = track_in;
      if (i == 13) trk14 = track_in;
    end
    cs_n_out = 1'b1;
  endtask : frame
endmodule : sac_host_model

`default_nettype wire

// [sim/tb.sv]
// Self-checking bench of the converter control block
`include "sac_consts.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sac_pkg::*;
  logic CLK_IN, RESET_IN, SCLK_IN, CS_N_IN, DOUT_OUT, COMP_IN, TRACK_OUT, PDOWN_OUT, CHAN_IN, CTRL_WR_IN;
  logic [12:0] DAC_CODE_OUT, RESULT_OUT, ain, res_seen, prev, expv;
  logic        RESULT_VALID_OUT;
  logic [5:0]  CTRL_WMASK_IN;
  sac_ctrl_t   CTRL_DATA_IN, CTRL_OUT, ctl;
  logic [21:0] LSB_NV_OUT;
  logic [12:0] rnd;
  int          err_total, num_checks, vcnt, rises;

  sac_adc_ctrl uut (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .SCLK_IN(SCLK_IN), .CS_N_IN(CS_N_IN),
    .DOUT_OUT(DOUT_OUT), .COMP_IN(COMP_IN), .DAC_CODE_OUT(DAC_CODE_OUT), .TRACK_OUT(TRACK_OUT),
    .PDOWN_OUT(PDOWN_OUT), .CHAN_IN(CHAN_IN), .CTRL_WR_IN(CTRL_WR_IN), .CTRL_WMASK_IN(CTRL_WMASK_IN),
    .CTRL_DATA_IN(CTRL_DATA_IN), .CTRL_OUT(CTRL_OUT), .RESULT_OUT(RESULT_OUT),
    .RESULT_VALID_OUT(RESULT_VALID_OUT), .LSB_NV_OUT(LSB_NV_OUT));
  sac_host_model host (.clk_in(CLK_IN), .dout_in(DOUT_OUT), .track_in(TRACK_OUT), .dac_in(DAC_CODE_OUT),
    .ain_in(ain), .sclk_out(SCLK_IN), .cs_n_out(CS_N_IN), .comp_out(COMP_IN));

  // 125 MHz clock
  initial begin
    CLK_IN = 1'b0;
    forever #4 CLK_IN = ~CLK_IN;
  end

  // Result pulse monitor
  always @(negedge CLK_IN) begin
    if (RESULT_VALID_OUT === 1'b1) begin
      vcnt++;
      res_seen = RESULT_OUT;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // Field-wise merge of a masked write
  function automatic sac_ctrl_t merge(sac_ctrl_t o, logic [5:0] m, sac_ctrl_t d);
    sac_ctrl_t r;
    r = o;
    if (m[`SAC_WM_STRAIGHT]) r.straight = d.straight;
    if (m[`SAC_WM_REF]) r.ref_int = d.ref_int;
    if (m[`SAC_WM_PM]) r.pm = d.pm;
    if (m[`SAC_WM_MODE]) r.mode = d.mode;
    if (m[`SAC_WM_RANGE0]) r.range0 = d.range0;
    if (m[`SAC_WM_RANGE1]) r.range1 = d.range1;
    return r;
  endfunction : merge

  // Step size of a range
  function automatic logic [21:0] lsb_of(sac_range_t r);
    case (r)
      SAC_PM10: return `SAC_LSB_NV_PM10;
      SAC_PM2P5: return `SAC_LSB_NV_PM2P5;
      default: return `SAC_LSB_NV_PM5;
    endcase
  endfunction : lsb_of

  task automatic wr(input logic [5:0] m, input sac_ctrl_t d);
    @(posedge CLK_IN);
    #1;
    CTRL_WR_IN = 1'b1;
    CTRL_WMASK_IN = m;
    CTRL_DATA_IN = d;
    ctl = merge(ctl, m, d);
    @(posedge CLK_IN);
    #1;
    CTRL_WR_IN = 1'b0;
    CTRL_WMASK_IN = 6'($urandom);
    chk(32'(CTRL_OUT), 32'(ctl));
  endtask : wr

  // Main sequence
  initial begin
    RESET_IN = 1'b1;
    CHAN_IN = 1'b0;
    CTRL_WR_IN = 1'b0;
    CTRL_WMASK_IN = 6'h00;
    CTRL_DATA_IN = '0;
    ain = 13'h0000;
    ctl = '0;
    prev = 13'h0000;
    err_total = 0;
    num_checks = 0;
    vcnt = 0;
    void'($urandom(32'h394c77b0));
    repeat (12) @(posedge CLK_IN);
    #1;
    RESET_IN = 1'b0;
    chk(32'(CTRL_OUT), 32'h0);
    chk(32'({TRACK_OUT, PDOWN_OUT, LSB_NV_OUT}), 32'({2'h2, `SAC_LSB_NV_PM10}));
    // Masked writes, reference bit alone first
    wr(6'h02, '1);
    for (int k = 0; k < 24; k++) begin
      rnd = 13'($urandom);
      wr(6'($urandom), sac_ctrl_t'(rnd));
    end
    // Conversions, frame five aborted early
    for (int k = 0; k < 17; k++) begin
      rnd = 13'($urandom);
      CTRL_DATA_IN = sac_ctrl_t'(rnd);
      CTRL_DATA_IN.mode = sac_mode_t'($urandom_range(0, 2));
      wr(6'h3f, CTRL_DATA_IN);
      ain = (k == 0) ? 13'h0000 : (k == 1) ? 13'h1fff : 13'($urandom);
      CHAN_IN = 1'($urandom);
      rises = (k == 5) ? 10 : 16;
      vcnt = 0;
      host.frame(rises);
      chk(32'(host.trk_hold), 32'h0);
      if (rises == 16) begin
        expv = ctl.straight ? ain : (ain ^ 13'h1000);
        chk(32'(host.word), {19'h0, prev});
        chk(vcnt, 1);
        chk(32'(res_seen), 32'(expv));
        chk(32'(DAC_CODE_OUT), 32'(ain));
        chk(32'({host.trk13, host.trk14}), 32'h1);
        chk(32'(LSB_NV_OUT), 32'(lsb_of((ctl.mode == SAC_SE && CHAN_IN) ? ctl.range1 : ctl.range0)));
        prev = expv;
      end
      #1000;
      chk(32'(PDOWN_OUT), 32'(ctl.pm != 2'h0));
      if (rises != 16) begin
        chk(vcnt, 0);
        chk(32'(TRACK_OUT), 32'h1);
      end
    end
    close_out();
  end
endmodule : tb

`default_nettype wire
